// ### rtl/scp_pkg.sv
// Package of the sensor configuration and write-guard register bank.
// Assumes a 100 MHz system clock; shared by the bank and its poll timer.
package scp_pkg;

    // Register offsets inside a bank
    localparam logic [7:0] CHIP_CONFIGURATION_OFS       = 8'h06;
    localparam logic [7:0] REGISTER_WRITE_GUARD_OFS     = 8'h09;
    localparam logic [7:0] LIGHT_SLEEP_POLL_SETTING_OFS = 8'h0A;

    // First bank-zero offset under the write guard
    localparam logic [7:0] GUARD_FIRST_OFS = 8'h0A;
    // Key value that opens the guarded registers
    localparam logic [7:0] GUARD_OPEN_KEY  = 8'h5A;

    // Configuration field positions and fixed patterns
    localparam int          CFG_SOFT_RESET_BIT = 7;
    localparam int          CFG_POWER_DOWN_BIT = 3;
    localparam logic [2:0]  CFG_HIGH_FIXED     = 3'h0;  // Bits 6:4
    localparam logic [2:0]  CFG_LOW_FIXED      = 3'h2;  // Bits 2:0

    // Sleep1 poll field position
    localparam int          POLL_FIELD_LSB = 4;
    localparam int          POLL_FIELD_W   = 4;

    // Reset values
    localparam logic        POWER_DOWN_RST  = 1'h0;
    localparam logic [7:0]  GUARD_RST       = 8'h00;
    localparam logic [3:0]  POLL_PERIOD_RST = 4'h2;

    // Poll period timing: period is (n + 1) steps
    localparam int SYS_CLK_PERIOD_NS = 10;
    localparam int POLL_STEP_MS      = 6;
    localparam int POLL_STEP_CYCLES  = (POLL_STEP_MS * 1000000) / SYS_CLK_PERIOD_NS;

endpackage : scp_pkg

// ### rtl/scp_poll_timer.sv
// Sleep1 poll timer: one-cycle tick every (period + 1) steps.
// Assumes the period input comes from a register in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module scp_poll_timer #(
    parameter int STEP_CYCLES = scp_pkg::POLL_STEP_CYCLES
) (
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_sys_rst,
    input  wire logic                        i_run,
    input  wire logic [scp_pkg::POLL_FIELD_W-1:0] i_period,
    output logic                             o_tick
);
    import scp_pkg::*;

    generate
        if (STEP_CYCLES < 1) begin : g_bad_step
            $error("STEP_CYCLES must be at least one");
        end
    endgenerate

    typedef struct packed {
        logic [31:0]             step_cnt;
        logic [POLL_FIELD_W-1:0] step_idx;
        logic                    tick;
    } scp_timer_t;

    scp_timer_t state;
    scp_timer_t next_state;

    // Step counter then step index; halted and cleared while not running
    always_comb begin
        next_state      = state;
        next_state.tick = 1'b0;
        if (!i_run) begin
            next_state.step_cnt = '0;
            next_state.step_idx = '0;
        end else if (state.step_cnt == 32'(STEP_CYCLES - 1)) begin
            next_state.step_cnt = '0;
            if (state.step_idx >= i_period) begin
                next_state.step_idx = '0;
                next_state.tick     = 1'b1;
            end else begin
                next_state.step_idx = state.step_idx + 4'h1;
            end
        end else begin
            next_state.step_cnt = state.step_cnt + 32'h1;
        end
    end

    // State register
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_tick = state.tick;

endmodule // scp_poll_timer
`default_nettype wire

// ### rtl/scp_sensor_config_regs.sv
// Configuration, write-guard and sleep1 poll registers of the sensor.
// Assumes the serial host port decoder delivers synchronous one-cycle
// read and write strobes with bank, offset and data.
// Assumes read data and status are taken one cycle after the strobe.
// Assumes the chip reset pulse is fanned out to the rest of the sensor.
// Assumes the poll tick is consumed by the sleep1 sensing sequencer.
`timescale 1ns/1ps
`default_nettype none
module scp_sensor_config_regs #(
    parameter int POLL_STEP_CYCLES = scp_pkg::POLL_STEP_CYCLES
) (
    input  wire logic                             i_sys_clk,
    input  wire logic                             i_sys_rst,
    input  wire logic                             i_reg_bank,
    input  wire logic [7:0]                       i_reg_addr,
    input  wire logic                             i_reg_wr,
    input  wire logic                             i_reg_rd,
    input  wire logic [7:0]                       i_reg_wdata,
    output logic      [7:0]                       o_reg_rdata,
    output logic                                  o_reg_rvalid,
    output logic                                  o_reg_wr_refused,
    output logic                                  o_chip_reset,
    output logic                                  o_power_down_enable,
    output logic                                  o_sense_enable,
    output logic      [scp_pkg::POLL_FIELD_W-1:0] o_light_sleep_poll_period,
    output logic                                  o_poll_tick
);
    import scp_pkg::*;

    // Refuse settings that the logic cannot serve
    generate
        if (POLL_STEP_CYCLES < 1) begin : g_bad_step
            $error("POLL_STEP_CYCLES must be at least one");
        end
        // Read packing places the poll field in bits 7:4
        if ((POLL_FIELD_LSB != 4) || (POLL_FIELD_W != 4)) begin : g_bad_field
            $error("Poll field must occupy bits 7:4");
        end
        // Configuration bits must lie inside the byte
        if ((CFG_SOFT_RESET_BIT > 7) || (CFG_POWER_DOWN_BIT > 7)) begin : g_bad_cfg
            $error("Configuration bit outside the register");
        end
        // The key and configuration registers must never lock themselves out
        if (REGISTER_WRITE_GUARD_OFS >= GUARD_FIRST_OFS) begin : g_bad_guard
            $error("Guard register lies inside the guarded range");
        end
        if (CHIP_CONFIGURATION_OFS >= GUARD_FIRST_OFS) begin : g_bad_cfg_ofs
            $error("Configuration register lies inside the guarded range");
        end
    endgenerate

    typedef struct packed {
        // Host port answers
        logic [7:0]              rdata;
        logic                    rvalid;
        logic                    wr_refused;
        // Chip control
        logic                    chip_reset;
        logic                    power_down_enable;
        logic                    sense_enable;
        // Stored registers
        logic [7:0]              guard;
        logic [POLL_FIELD_W-1:0] poll_period;
    } scp_regs_t;

    // Registered state and its next value
    scp_regs_t state;
    scp_regs_t next_state;
    // Decode helpers
    logic      guard_open;
    logic      is_guarded;
    logic      poll_tick;
    logic      run_timer;

    // Guard decode
    // The key must match exactly; any other value, the reset value included,
    // keeps bank one and the upper bank-zero offsets locked. The key and
    // configuration registers sit below the guarded range, so a host can
    // always unlock the bank or reset the chip.
    assign guard_open = (state.guard == GUARD_OPEN_KEY);
    assign is_guarded = i_reg_bank || (i_reg_addr >= GUARD_FIRST_OFS);
    // The poll timer runs only while sensing
    assign run_timer  = state.sense_enable;

    // Register read, write and soft reset sequencing
    // Status is a one-cycle registered answer, cleared first so that every path
    // leaves it defined; read data holds until the next read or chip reset. A soft
    // reset takes one whole cycle, during which strobes are dropped without an
    // answer, so the host never sees a reply from a half-reset bank.
    always_comb begin
        next_state            = state;
        next_state.rvalid     = 1'b0;
        next_state.wr_refused = 1'b0;
        next_state.chip_reset = 1'b0;
        if (state.chip_reset) begin
            // Full chip reset: every register back to its default
            // Read data is cleared too, so nothing from before the reset
            // can be picked up afterwards.
            next_state.power_down_enable = POWER_DOWN_RST;
            next_state.sense_enable      = ~POWER_DOWN_RST;
            next_state.guard             = GUARD_RST;
            next_state.poll_period       = POLL_PERIOD_RST;
            next_state.rdata             = 8'h00;
        end else begin
            // Writes: refused inside the locked range, dropped at unmapped
            // offsets and everywhere in bank one, which holds no register here
            if (i_reg_wr) begin
                // Locked: answer with a refusal and change nothing
                if (is_guarded && !guard_open) begin
                    next_state.wr_refused = 1'b1;
                end else if (!i_reg_bank) begin
                    unique case (i_reg_addr)
                        CHIP_CONFIGURATION_OFS: begin
                            // Fixed bit groups are not stored
                            // They read back as the required pattern, so a
                            // host that breaks the pattern cannot change them
                            next_state.chip_reset =
                                i_reg_wdata[CFG_SOFT_RESET_BIT];
                            next_state.power_down_enable =
                                i_reg_wdata[CFG_POWER_DOWN_BIT];
                            next_state.sense_enable =
                                ~i_reg_wdata[CFG_POWER_DOWN_BIT];
                        end
                        REGISTER_WRITE_GUARD_OFS: begin
                            // Any value may be stored; only the key opens
                            next_state.guard = i_reg_wdata;
                        end
                        LIGHT_SLEEP_POLL_SETTING_OFS: begin
                            // Low nibble is not stored
                            next_state.poll_period =
                                i_reg_wdata[POLL_FIELD_LSB +: POLL_FIELD_W];
                        end
                        default: begin
                            // Unmapped offset: nothing is stored
                            next_state.guard = state.guard;
                        end
                    endcase
                end
            end
            // Reads: a read in the same cycle as a write sees the old value;
            // locked, unmapped and bank-one offsets read as zero
            if (i_reg_rd) begin
                next_state.rvalid = 1'b1;
                next_state.rdata  = 8'h00;
                // Locked offsets and bank one keep the zero above
                if (!(is_guarded && !guard_open) && !i_reg_bank) begin
                    unique case (i_reg_addr)
                        CHIP_CONFIGURATION_OFS: begin
                            // Soft reset bit always reads zero once taken
                            next_state.rdata = {1'b0, CFG_HIGH_FIXED,
                                state.power_down_enable, CFG_LOW_FIXED};
                        end
                        REGISTER_WRITE_GUARD_OFS: begin
                            // The key reads back as written
                            next_state.rdata = state.guard;
                        end
                        LIGHT_SLEEP_POLL_SETTING_OFS: begin
                            // Low nibble reads zero
                            next_state.rdata = {state.poll_period, 4'h0};
                        end
                        default: begin
                            // Unmapped offset reads zero
                            next_state.rdata = 8'h00;
                        end
                    endcase
                end
            end
        end
    end

    // State register with defaults on reset
    // Reset is synchronous; the guard comes up locked and the poll field
    // at its default period of three steps.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            // Clear everything, then load the non-zero defaults
            state                   <= '0;
            state.power_down_enable <= POWER_DOWN_RST;
            state.sense_enable      <= ~POWER_DOWN_RST;
            state.guard             <= GUARD_RST;
            state.poll_period       <= POLL_PERIOD_RST;
        end else begin
            state <= next_state;
        end
    end

    // Sleep1 poll period timer, halted in power-down
    // The timer restarts from zero on chip reset and whenever sensing is
    // switched back on, so the first tick after either comes one full
    // period later. A new period takes effect at the next step boundary.
    scp_poll_timer #(
        .STEP_CYCLES (POLL_STEP_CYCLES)
    ) u_poll_timer (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst || state.chip_reset),
        .i_run     (run_timer),
        .i_period  (state.poll_period),
        .o_tick    (poll_tick)
    );

    // Outputs straight from flip-flops
    // No output is decoded combinationally, so the host port sees clean
    // levels and pulses that last exactly one cycle.
    assign o_reg_rdata               = state.rdata;
    assign o_reg_rvalid              = state.rvalid;
    assign o_reg_wr_refused          = state.wr_refused;
    assign o_chip_reset              = state.chip_reset;
    assign o_power_down_enable       = state.power_down_enable;
    assign o_sense_enable            = state.sense_enable;
    assign o_light_sleep_poll_period = state.poll_period;
    assign o_poll_tick               = poll_tick;

endmodule // scp_sensor_config_regs
`default_nettype wire

// ### bench/scp_regs_checker.sv
// Port checker of the sensor register bank.
// Assumes it is bound into scp_sensor_config_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module scp_regs_checker (
    input wire logic       i_sys_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_reg_bank,
    input wire logic [7:0] i_reg_addr,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       o_reg_rvalid,
    input wire logic       o_reg_wr_refused,
    input wire logic       o_chip_reset,
    input wire logic       o_power_down_enable,
    input wire logic       o_sense_enable,
    input wire logic [3:0] o_light_sleep_poll_period
);
    logic [7:0] key;
    wire        opn = key == 8'h5A;
    wire        grd = i_reg_bank || i_reg_addr >= 8'h0A;
    wire        wr0 = i_reg_wr && !o_chip_reset;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // Guard key as last written on the port
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || o_chip_reset) key <= 8'h00;
        else if (wr0 && !i_reg_bank && i_reg_addr == 8'h09) key <= i_reg_wdata;
    end
    sequence s_cfg_wr; wr0 && !i_reg_bank && i_reg_addr == 8'h06; endsequence
    sequence s_poll_wr; wr0 && !i_reg_bank && i_reg_addr == 8'h0A && opn; endsequence
    sequence s_dflt; o_light_sleep_poll_period == 4'h2 && !o_power_down_enable; endsequence
    a_soft_reset: assert property (s_cfg_wr ##0 i_reg_wdata[7] |=> o_chip_reset ##1 s_dflt)
        else $error("soft reset missed");
    a_guard_lock: assert property (wr0 && grd && !opn |=> o_reg_wr_refused)
        else $error("locked write accepted");
    a_guard_open: assert property (wr0 && opn |=> !o_reg_wr_refused)
        else $error("open write refused");
    a_locked_read: assert property (i_reg_rd && !o_chip_reset && grd && !opn
        |=> o_reg_rvalid && o_reg_rdata == 8'h00) else $error("locked read leaked");
    a_poll_store: assert property (s_poll_wr |=>
        {o_light_sleep_poll_period, 4'h0} == ($past(i_reg_wdata) & 8'hF0))
        else $error("poll field lost");
    a_power_down: assert property (s_cfg_wr |=> o_sense_enable != o_power_down_enable &&
        o_power_down_enable == |($past(i_reg_wdata) & 8'h08)) else $error("power down wrong");
    a_reset_dflt: assert property ($fell(i_sys_rst) |-> s_dflt)
        else $error("reset defaults wrong");
endmodule // scp_regs_checker
bind scp_sensor_config_regs scp_regs_checker i_checker (
    .i_sys_clk                 (i_sys_clk),
    .i_sys_rst                 (i_sys_rst),
    .i_reg_bank                (i_reg_bank),
    .i_reg_addr                (i_reg_addr),
    .i_reg_wr                  (i_reg_wr),
    .i_reg_rd                  (i_reg_rd),
    .i_reg_wdata               (i_reg_wdata),
    .o_reg_rdata               (o_reg_rdata),
    .o_reg_rvalid              (o_reg_rvalid),
    .o_reg_wr_refused          (o_reg_wr_refused),
    .o_chip_reset              (o_chip_reset),
    .o_power_down_enable       (o_power_down_enable),
    .o_sense_enable            (o_sense_enable),
    .o_light_sleep_poll_period (o_light_sleep_poll_period)
);
`default_nettype wire

// ### bench/scp_host_model.sv
// Host controller model on the register port of the sensor bank.
// Assumes strobes are taken on the rising edge and answered a cycle later.
`timescale 1ns/1ps
`default_nettype none
module scp_host_model (
    input  wire logic       i_sys_clk,
    input  wire logic [7:0] i_reg_rdata,
    input  wire logic       i_reg_rvalid,
    input  wire logic       i_reg_wr_refused,
    input  wire logic       i_chip_reset,
    output logic            o_reg_bank,
    output logic [7:0]      o_reg_addr,
    output logic            o_reg_wr,
    output logic            o_reg_rd,
    output logic [7:0]      o_reg_wdata
);
    // Idle port from time zero
    initial begin
        o_reg_bank = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_wdata = 8'h00;
    end
    // One byte: strobe for one cycle, answer taken one cycle later
    task automatic xfer(input logic w, input logic b, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic [2:0] st);
        @(negedge i_sys_clk);
        o_reg_bank = b;
        o_reg_addr = a;
        o_reg_wdata = (!b && a == 8'h06) ? {d[7], 3'h0, d[3], 3'h2} : d;
        o_reg_wr = w;
        o_reg_rd = !w;
        @(negedge i_sys_clk);
        q = i_reg_rdata;
        st = {i_reg_rvalid, i_reg_wr_refused, i_chip_reset};
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = ~o_reg_addr; // Released lines lose their value
        o_reg_wdata = ~o_reg_wdata;
    endtask
endmodule // scp_host_model
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench of the sensor configuration and write-guard bank.
// Assumes the host model on the register port and a four-cycle poll step.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int STEP = 4;
    logic        i_sys_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        bank, wr, rd, refused, chip_rst, rvalid, pd, sense, tick;
    logic [7:0]  addr, wdata, rdata, ad;
    logic [3:0]  period;
    logic [15:0] lfsr = 16'h8FFF;
    int          miscompares = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          c;
    scp_sensor_config_regs #(.POLL_STEP_CYCLES(STEP)) i_dut (.i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst), .i_reg_bank(bank), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .o_reg_wr_refused(refused), .o_chip_reset(chip_rst), .o_power_down_enable(pd),
        .o_sense_enable(sense), .o_light_sleep_poll_period(period), .o_poll_tick(tick));
    scp_host_model i_host (.i_sys_clk(i_sys_clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
        .i_reg_wr_refused(refused), .i_chip_reset(chip_rst), .o_reg_bank(bank),
        .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_wdata(wdata));
    // Clock and cycle ceiling
    initial forever #5 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] poll_gap(input logic [3:0] n);
        return 16'((n + 1) * STEP);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Transfer with expected status {rvalid, refused, chip reset} and read data
    task automatic rw(input logic w, input logic b, input logic [7:0] a, input logic [7:0] d,
                      input logic [7:0] eq, input logic [2:0] est);
        logic [7:0] q;
        logic [2:0] st;
        i_host.xfer(w, b, a, d, q, st);
        chk({13'h0, st}, {13'h0, est});
        if (!w) chk({8'h0, q}, {8'h0, eq});
    endtask
    // Cycles between two poll ticks, bounded
    task automatic gap(output int n);
        n = 0;
        while (tick !== 1'b1 && n < 300) begin
            @(negedge i_sys_clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge i_sys_clk);
            n++;
        end while (tick !== 1'b1 && n < 300);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(negedge i_sys_clk);
        i_sys_rst = 1'b0;
        rw(1'b0, 1'b0, 8'h06, 8'h00, 8'h02, 3'b100);
        rw(1'b0, 1'b0, 8'h0A, 8'h00, 8'h00, 3'b100);
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            ad = lfsr[8] ? {1'b0, lfsr[6:0]} : 8'h0A + {2'h0, lfsr[5:0]};
            rw(1'b1, lfsr[8], ad, lfsr[15:8], 8'h00, 3'b010);
        end
        ad = (lfsr[7:0] == 8'h5A) ? 8'h5B : lfsr[7:0];
        rw(1'b1, 1'b0, 8'h09, ad, 8'h00, 3'b000);
        rw(1'b1, 1'b0, 8'h0A, 8'h30, 8'h00, 3'b010);
        rw(1'b1, 1'b0, 8'h09, 8'h5A, 8'h00, 3'b000);
        rw(1'b0, 1'b0, 8'h0A, 8'h00, 8'h20, 3'b100);
        $display("test guard done");
        for (int i = 0; i < 16; i++) begin
            lfsr = lfsr_next(lfsr);
            rw(1'b1, 1'b0, 8'h0A, {4'(i), lfsr[3:0]}, 8'h00, 3'b000);
            rw(1'b0, 1'b0, 8'h0A, 8'h00, {4'(i), 4'h0}, 3'b100);
            gap(c);
            gap(c);
            chk(16'(c), poll_gap(4'(i)));
        end
        $display("test poll done");
        rw(1'b1, 1'b0, 8'h06, 8'h08, 8'h00, 3'b000);
        chk({14'h0, pd, sense}, 16'h0002);
        c = 0;
        repeat (100) @(negedge i_sys_clk) if (tick === 1'b1) c++;
        chk(16'(c), 16'h0000);
        rw(1'b1, 1'b0, 8'h06, 8'h00, 8'h00, 3'b000);
        gap(c);
        gap(c);
        chk(16'(c), poll_gap(4'hF));
        $display("test power down done");
        rw(1'b1, 1'b0, 8'h06, 8'h88, 8'h00, 3'b001);
        rw(1'b0, 1'b0, 8'h06, 8'h00, 8'h02, 3'b100);
        rw(1'b0, 1'b0, 8'h09, 8'h00, 8'h00, 3'b100);
        chk({12'h0, period}, 16'h0002);
        $display("test soft reset done");
        finish_test();
    end
endmodule // testbench
`default_nettype wire
